// >>> core/tiop_defines.svh
`ifndef TIOP_DEFINES_SVH
`define TIOP_DEFINES_SVH

// Geometry
`define TIOP_PINS       32
`define TIOP_CNT_W      16
`define TIOP_DIV_W      8
`define TIOP_NUM_CB     6

// Register byte offsets
`define TIOP_OFS_CTRL   8'h00
`define TIOP_OFS_DATA   8'h04
`define TIOP_OFS_COUNT  8'h08
`define TIOP_OFS_TIME   8'h0C
`define TIOP_OFS_TSTAMP 8'h10
`define TIOP_OFS_COND   8'h14
`define TIOP_OFS_STATUS 8'h18
`define TIOP_OFS_MASK   8'h1C
`define TIOP_OFS_FLAGS  8'h20
`define TIOP_OFS_CB_BASE 3'h2

// Status bit positions
`define TIOP_ST_XFER    0
`define TIOP_ST_COND    1
`define TIOP_ST_OVR     2

// Width codes
`define TIOP_W1         3'h0
`define TIOP_W4         3'h1
`define TIOP_W8         3'h2
`define TIOP_W16        3'h3

// Reset values
`define TIOP_CTRL_RST   12'h000
`define TIOP_MASK_RST   3'h0

`endif

// >>> core/tiop_pkg.sv
package tiop_pkg;

  typedef enum logic [1:0] {
    TIOP_IDLE  = 2'b00,
    TIOP_WAIT  = 2'b01,
    TIOP_SHIFT = 2'b11
  } tiop_xs_e;

  typedef struct packed {
    logic [2:0] cb_sel;
    logic [2:0] wcode;
    logic       strobe_en;
    logic       cond_neq;
    logic       cond_en;
    logic       od;
    logic       dir_out;
    logic       en;
  } tiop_ctrl_s;

  typedef struct packed {
    tiop_xs_e        xs;
    tiop_ctrl_s      ctrl;
    logic [15:0]     cnt;
    logic [15:0]     time_v;
    logic            tm_arm;
    logic [15:0]     tstamp;
    logic [31:0]     cond_v;
    logic [2:0]      sts;
    logic [2:0]      mask;
    logic [31:0]     xfer;
    logic            xfull;
    logic            ivalid;
    logic [31:0]     sr;
    logic [5:0]      nleft;
    logic [31:0]     drv;
    logic [5:1]      cb_src;
    logic [5:1][7:0] cb_div;
    logic [5:1][7:0] cb_cnt;
    logic            ext_q;
    logic            ack;
    logic [31:0]     dat_o;
    logic [31:0]     pin_o;
    logic [31:0]     pin_oe;
    logic            ostb;
    logic            pull_dn;
    logic            irq;
    logic            evt;
  } tiop_st_s;

endpackage

// >>> core/tiop_port.sv
// The implementer's own choices: register access over Wishbone and the address map.
`timescale 1ns/100ps
`include "tiop_defines.svh"
// Notes on behaviour
// - Widths 1/4/8/16/32; one direction per port
// - Drive pins or sample, optional condition stall
// - Every register access answers in one cycle
// - Open drain: zero drives low, one floats
// - Shift register plus transfer register buffer
// - 16-bit counter times each transfer
// - Counter readable; programmed time defers next transfer
// - Counter captured as timestamp on transfer
// - Enabled link disables port pins
// - Narrower port wins shared pins
// - Transfer always at full width
// - Six clock blocks; block 0 is reference
// - Clock block from 1-bit pin, optional divide
// - Input strobe honoured, output strobe generated
// - After reset port uses clock block 0
// - Pin events go straight to scheduler
// - Pull-downs enabled while in reset
module tiop_port
  import tiop_pkg::*;
(
  // System
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Pins
  input  wire logic [31:0] pin_i,
  output logic [31:0]      pin_o,
  output logic [31:0]      pin_oe,
  output logic             pull_dn,
  // External clock and strobes
  input  wire logic        ext_clk_pin,
  input  wire logic        ready_in,
  output logic             output_strobe,
  // Pin sharing
  input  wire logic        link_en,
  input  wire logic [31:0] claim_mask,
  // Events and interrupt
  output logic             sched_event,
  output logic             irq
);

  tiop_st_s st;
  tiop_st_s nxt;

  logic [5:0]  pw;
  logic [5:0]  beats;
  logic [31:0] lanes;
  logic [5:0]  tick;
  logic        ptick;
  logic        ext_edge;
  logic        src_edge;
  logic        req;
  logic        wr;
  logic        rd;
  logic        cond_ok;
  logic        go;
  logic        beat;
  logic [2:0]  sts_set;
  logic [2:0]  sts_clr;
  logic [31:0] rdat;
  logic [2:0]  cbi;

  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = n[8*b +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Width decode
  always_comb begin
    case (st.ctrl.wcode)
      `TIOP_W1: begin
        pw = 6'd1;
        beats = 6'd32;
      end
      `TIOP_W4: begin
        pw = 6'd4;
        beats = 6'd8;
      end
      `TIOP_W8: begin
        pw = 6'd8;
        beats = 6'd4;
      end
      `TIOP_W16: begin
        pw = 6'd16;
        beats = 6'd2;
      end
      default: begin
        pw = 6'd32;
        beats = 6'd1;
      end
    endcase
    lanes = (pw == 6'd32) ? 32'hFFFFFFFF : ((32'h1 << pw) - 32'h1);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock blocks: block 0 ticks every reference cycle
  assign ext_edge = ext_clk_pin & ~st.ext_q;
  always_comb begin
    tick[0] = 1'b1;
    src_edge = 1'b0;
    for (int n = 1; n < `TIOP_NUM_CB; n++) begin
      src_edge = st.cb_src[n] ? ext_edge : 1'b1;
      tick[n] = src_edge && (st.cb_cnt[n] == st.cb_div[n]);
    end
    cbi = (st.ctrl.cb_sel > 3'h5) ? 3'h0 : st.ctrl.cb_sel;
    ptick = tick[cbi];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus and sequencer
  assign req = wb_cyc_i & wb_stb_i & ~st.ack;
  assign wr = req & wb_we_i;
  assign rd = req & ~wb_we_i;
  assign cond_ok = st.ctrl.cond_neq ? ((pin_i & lanes) != (st.cond_v & lanes))
                                    : ((pin_i & lanes) == (st.cond_v & lanes));
  assign go = ptick && (!st.tm_arm || st.cnt == st.time_v)
              && (st.ctrl.dir_out || !st.ctrl.cond_en || cond_ok)
              && (st.ctrl.dir_out || !st.ctrl.strobe_en || ready_in);
  assign beat = ptick && (st.ctrl.dir_out || !st.ctrl.strobe_en || ready_in);

  always_comb begin
    case (wb_adr_i)
      `TIOP_OFS_CTRL:   rdat = {20'h0, st.ctrl};
      `TIOP_OFS_DATA:   rdat = st.xfer;
      `TIOP_OFS_COUNT:  rdat = {16'h0, st.cnt};
      `TIOP_OFS_TIME:   rdat = {16'h0, st.time_v};
      `TIOP_OFS_TSTAMP: rdat = {16'h0, st.tstamp};
      `TIOP_OFS_COND:   rdat = st.cond_v;
      `TIOP_OFS_STATUS: rdat = {29'h0, st.sts};
      `TIOP_OFS_MASK:   rdat = {29'h0, st.mask};
      `TIOP_OFS_FLAGS:  rdat = {29'h0, st.tm_arm, st.ivalid, st.xfull};
      default: begin
        if (wb_adr_i[7:5] == `TIOP_OFS_CB_BASE && wb_adr_i[4:2] >= 3'h1
            && wb_adr_i[4:2] <= 3'h5 && wb_adr_i[1:0] == 2'h0) begin
          rdat = {16'h0, st.cb_div[wb_adr_i[4:2]], 7'h0, st.cb_src[wb_adr_i[4:2]]};
        end else begin
          rdat = 32'h0;
        end
      end
    endcase
  end

  always_comb begin
    nxt = st;
    sts_set = 3'h0;
    sts_clr = 3'h0;
    nxt.evt = 1'b0;
    nxt.ext_q = ext_clk_pin;
    nxt.pull_dn = 1'b0;
    nxt.ack = req;
    nxt.dat_o = rd ? rdat : st.dat_o;
    // Clock block dividers
    for (int n = 1; n < `TIOP_NUM_CB; n++) begin
      if (st.cb_src[n] ? ext_edge : 1'b1) begin
        nxt.cb_cnt[n] = tick[n] ? 8'h0 : 8'(st.cb_cnt[n] + 8'h1);
      end
    end
    if (ptick) begin
      nxt.cnt = 16'(st.cnt + 16'h1);
    end
    // Register writes
    if (wr) begin
      case (wb_adr_i)
        `TIOP_OFS_CTRL:
          nxt.ctrl = tiop_ctrl_s'(12'(wmerge({20'h0, st.ctrl}, wb_dat_i, wb_sel_i)));
        `TIOP_OFS_DATA: begin
          nxt.xfer = wmerge(st.xfer, wb_dat_i, wb_sel_i);
          nxt.xfull = 1'b1;
        end
        `TIOP_OFS_TIME: begin
          nxt.time_v = 16'(wmerge({16'h0, st.time_v}, wb_dat_i, wb_sel_i));
          nxt.tm_arm = 1'b1;
        end
        `TIOP_OFS_COND:   nxt.cond_v = wmerge(st.cond_v, wb_dat_i, wb_sel_i);
        `TIOP_OFS_STATUS: sts_clr = wb_sel_i[0] ? wb_dat_i[2:0] : 3'h0;
        `TIOP_OFS_MASK:   nxt.mask = wb_sel_i[0] ? wb_dat_i[2:0] : st.mask;
        default: begin
          if (wb_adr_i[7:5] == `TIOP_OFS_CB_BASE && wb_adr_i[4:2] >= 3'h1
              && wb_adr_i[4:2] <= 3'h5 && wb_adr_i[1:0] == 2'h0) begin
            if (wb_sel_i[0]) begin
              nxt.cb_src[wb_adr_i[4:2]] = wb_dat_i[0];
            end
            if (wb_sel_i[1]) begin
              nxt.cb_div[wb_adr_i[4:2]] = wb_dat_i[15:8];
              nxt.cb_cnt[wb_adr_i[4:2]] = 8'h0;
            end
          end
        end
      endcase
    end
    if (rd && wb_adr_i == `TIOP_OFS_DATA) begin
      nxt.ivalid = 1'b0;
    end
    // Transfer sequencer
    case (st.xs)
      TIOP_IDLE: begin
        if (st.ctrl.en && (!st.ctrl.dir_out || st.xfull)) begin
          nxt.xs = TIOP_WAIT;
        end
      end
      TIOP_WAIT: begin
        if (!st.ctrl.en) begin
          nxt.xs = TIOP_IDLE;
        end else if (go) begin
          nxt.xs = TIOP_SHIFT;
          nxt.tm_arm = 1'b0;
          nxt.nleft = beats;
          nxt.sr = st.ctrl.dir_out ? st.xfer : 32'h0;
          if (st.ctrl.dir_out) begin
            nxt.xfull = 1'b0;
            nxt.tstamp = st.cnt;
          end
          if (!st.ctrl.dir_out && st.ctrl.cond_en) begin
            sts_set[`TIOP_ST_COND] = 1'b1;
            nxt.evt = 1'b1;
          end
        end
      end
      TIOP_SHIFT: begin
        if (beat) begin
          nxt.nleft = 6'(st.nleft - 6'h1);
          if (st.ctrl.dir_out) begin
            nxt.drv = st.sr & lanes;
            nxt.sr = st.sr >> pw;
          end else begin
            nxt.sr = (st.sr >> pw) | ((pin_i & lanes) << (6'd32 - pw));
          end
          if (st.nleft == 6'h1) begin
            nxt.xs = TIOP_IDLE;
            sts_set[`TIOP_ST_XFER] = 1'b1;
            nxt.evt = 1'b1;
            if (!st.ctrl.dir_out) begin
              nxt.xfer = (st.sr >> pw) | ((pin_i & lanes) << (6'd32 - pw));
              nxt.tstamp = st.cnt;
              nxt.ivalid = 1'b1;
              sts_set[`TIOP_ST_OVR] = st.ivalid;
            end
          end
        end
      end
      default: nxt.xs = TIOP_IDLE;
    endcase
    // Set wins over clear
    nxt.sts = (st.sts & ~sts_clr) | sts_set;
    nxt.irq = |(st.sts & st.mask);
    nxt.ostb = st.ctrl.strobe_en & st.ctrl.dir_out & (st.xs == TIOP_SHIFT);
    // Pin drivers
    for (int i = 0; i < `TIOP_PINS; i++) begin
      if (st.ctrl.en && st.ctrl.dir_out && !link_en
          && !claim_mask[i] && lanes[i]) begin
        nxt.pin_oe[i] = st.ctrl.od ? ~st.drv[i] : 1'b1;
        nxt.pin_o[i] = st.ctrl.od ? 1'b0 : st.drv[i];
      end else begin
        nxt.pin_oe[i] = 1'b0;
        nxt.pin_o[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
      st.xs <= TIOP_IDLE;
      st.ctrl <= `TIOP_CTRL_RST;
      st.mask <= `TIOP_MASK_RST;
      st.pull_dn <= 1'b1;
    end else begin
      st <= nxt;
    end
  end

  assign wb_dat_o = st.dat_o;
  assign wb_ack_o = st.ack;
  assign pin_o = st.pin_o;
  assign pin_oe = st.pin_oe;
  assign pull_dn = st.pull_dn;
  assign output_strobe = st.ostb;
  assign sched_event = st.evt;
  assign irq = st.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb_chk @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  chk_ack_one_cycle: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle pulse");
  chk_od_no_high: assert property (
    $past(st.ctrl.od) |-> (pin_o & pin_oe) == 32'h0)
    else $error("open drain drove a high");
  chk_link_off: assert property ($past(link_en) |-> pin_oe == 32'h0)
    else $error("pins driven while link enabled");
  chk_claim_prio: assert property (
    (($past(claim_mask) & pin_oe) == 32'h0))
    else $error("claimed pin still driven");
  chk_dir_single: assert property ((pin_oe != 32'h0) |-> $past(st.ctrl.dir_out))
    else $error("pins driven on input port");
  chk_cnt_tick: assert property (
    ptick |=> st.cnt == 16'($past(st.cnt) + 16'h1))
    else $error("counter did not advance on tick");
  chk_cnt_hold: assert property (!ptick |=> $stable(st.cnt))
    else $error("counter moved without tick");
  chk_ts_capture: assert property (
    (st.xs == TIOP_SHIFT && beat && st.nleft == 6'h1 && !st.ctrl.dir_out)
    |=> st.tstamp == $past(st.cnt) && st.ivalid)
    else $error("timestamp not captured");
  chk_time_defer: assert property (
    (st.xs == TIOP_WAIT && st.tm_arm && st.cnt != st.time_v) |=> st.xs != TIOP_SHIFT)
    else $error("transfer before programmed time");
  chk_evt_direct: assert property (
    (st.xs == TIOP_SHIFT && beat && st.nleft == 6'h1) |=> sched_event ##1 !sched_event)
    else $error("event not raised after transfer");

endmodule

// >>> tb/tiop_ext_hw.sv
`timescale 1ns/100ps
module tiop_ext_hw (
  // Device side
  input  wire logic        clk_sys,
  input  wire logic [31:0] pin_o,
  input  wire logic [31:0] pin_oe,
  // Bench controls
  input  wire logic [31:0] ext_val,
  input  wire logic        clk_run,
  input  wire logic        rdy,
  // Toward device
  output logic [31:0]      pin_i,
  output logic             ext_clk_pin,
  output logic             ready_in
);
  logic tgl = 1'b0;
  // Wire level: device where it drives, application hardware elsewhere
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_val);
  assign ready_in = rdy;
  // Application clock stands still low unless running
  always @(posedge clk_sys) begin
    tgl <= ~tgl;
  end
  assign ext_clk_pin = clk_run & tgl;
endmodule

// >>> tb/tb.sv
`timescale 1ns/100ps
`include "tiop_defines.svh"
module tb;
  logic        clk_sys = 1'b0, resetn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic        link_en = 1'b0, clk_run = 1'b0, rdy = 1'b0, saw_os = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0, claim_mask = 32'h0, ext_val = 32'h0, q, r, c;
  wire  [31:0] wb_dat_o, pin_i, pin_o, pin_oe;
  wire         wb_ack_o, pull_dn, ext_clk_pin, ready_in, output_strobe, sched_event, irq;
  int          err_count = 0, cmp_count = 0, cyc_n = 0, ev_n = 0;
  logic [31:0] eq[$], mq[$];

  tiop_port DUT (.clk_sys(clk_sys), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .pull_dn(pull_dn),
    .ext_clk_pin(ext_clk_pin), .ready_in(ready_in), .output_strobe(output_strobe),
    .link_en(link_en), .claim_mask(claim_mask), .sched_event(sched_event), .irq(irq));
  tiop_ext_hw ext (.clk_sys(clk_sys), .pin_o(pin_o), .pin_oe(pin_oe), .ext_val(ext_val),
    .clk_run(clk_run), .rdy(rdy), .pin_i(pin_i), .ext_clk_pin(ext_clk_pin),
    .ready_in(ready_in));

  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic close_out;
    if (err_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Classic cycle: hold until ack seen, then release for a cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    @(negedge clk_sys);
    while (wb_ack_o !== 1'b1) @(negedge clk_sys);
    @(posedge clk_sys);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    eq.push_back(e);
    mq.push_back(m);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic wait_bit(input logic [7:0] a, input int b);
    repeat (200) begin
      rd(a, 32'h0, 32'h0);
      if (q[b] === 1'b1) break;
    end
  endtask

  task automatic settle;
    repeat (3) @(negedge clk_sys);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Watcher: read data against notes, event and strobe tally, timeout
  always @(negedge clk_sys) begin
    cyc_n++;
    if (cyc_n > 20000) begin
      err_count++;
      close_out();
    end
    if (sched_event === 1'b1) ev_n++;
    if (output_strobe === 1'b1) saw_os = 1'b1;
    if (wb_ack_o === 1'b1 && we === 1'b0 && eq.size() > 0)
      check("rdata", wb_dat_o & mq.pop_front(), eq.pop_front());
  end

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    r = $urandom(32'h6aa6);
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    check("pull_dn", {31'h0, pull_dn}, 32'h1);
    check("pin_oe", pin_oe, 32'h0);
    @(posedge clk_sys);
    resetn <= 1'b1;
    settle();
    check("pull_dn", {31'h0, pull_dn}, 32'h0);
    rd(`TIOP_OFS_CTRL, 32'h0, 32'hFFFFFFFF);
    rd(`TIOP_OFS_MASK, 32'h0, 32'h7);
    rd(8'hF0, 32'h0, 32'hFFFFFFFF);
    rd(`TIOP_OFS_COUNT, 32'h0, 32'h0);
    c = {16'h0, q[15:0] + 16'h3};
    rd(`TIOP_OFS_COUNT, c, 32'hFFFFFFFF);
    // Eight-bit output with strobe
    r = $urandom;
    wr(`TIOP_OFS_CTRL, 32'h000000A3);
    wr(`TIOP_OFS_DATA, r);
    wait_bit(`TIOP_OFS_STATUS, `TIOP_ST_XFER);
    check("last_beat", {24'h0, pin_o[7:0]}, {24'h0, r[31:24]});
    check("drive", {24'h0, pin_oe[7:0]}, 32'hFF);
    check("ostrobe", {31'h0, saw_os}, 32'h1);
    check("events", ev_n, 32'h1);
    @(posedge clk_sys);
    claim_mask <= 32'h0000000F;
    settle();
    check("shared", {24'h0, pin_oe[7:0]}, 32'hF0);
    @(posedge clk_sys);
    link_en <= 1'b1;
    settle();
    check("link", pin_oe, 32'h0);
    @(posedge clk_sys);
    link_en <= 1'b0;
    claim_mask <= 32'h0;
    // Interrupt raised, masked, cleared
    check("irq_off", {31'h0, irq}, 32'h0);
    wr(`TIOP_OFS_MASK, 32'h1);
    settle();
    check("irq_on", {31'h0, irq}, 32'h1);
    wr(`TIOP_OFS_STATUS, 32'h1);
    settle();
    check("irq_clr", {31'h0, irq}, 32'h0);
    rd(`TIOP_OFS_STATUS, 32'h0, 32'h1);
    // Deferred open-drain output
    rd(`TIOP_OFS_COUNT, 32'h0, 32'h0);
    c = {16'h0, q[15:0] + 16'd60};
    wr(`TIOP_OFS_CTRL, 32'h000000A7);
    wr(`TIOP_OFS_TIME, c);
    rd(`TIOP_OFS_FLAGS, 32'h4, 32'h4);
    wr(`TIOP_OFS_DATA, {8'hA5, r[23:0]});
    wait_bit(`TIOP_OFS_STATUS, `TIOP_ST_XFER);
    rd(`TIOP_OFS_TSTAMP, c, 32'hFFFFFFFF);
    check("od_oe", {24'h0, pin_oe[7:0]}, 32'h5A);
    check("od_low", {24'h0, pin_o[7:0] & pin_oe[7:0]}, 32'h0);
    check("events", ev_n, 32'h2);
    // Full-width input gated by the input strobe
    r = $urandom;
    @(posedge clk_sys);
    ext_val <= r;
    wr(`TIOP_OFS_CTRL, 32'h00000121);
    repeat (20) @(negedge clk_sys);
    check("in_dir", pin_oe, 32'h0);
    rd(`TIOP_OFS_FLAGS, 32'h0, 32'h2);
    @(posedge clk_sys);
    rdy <= 1'b1;
    wait_bit(`TIOP_OFS_FLAGS, 1);
    rd(`TIOP_OFS_DATA, r, 32'hFFFFFFFF);
    // Counter frozen while the external clock stands still
    wr(8'h44, 32'h00000101);
    wr(`TIOP_OFS_CTRL, 32'h00000201);
    rd(`TIOP_OFS_COUNT, 32'h0, 32'h0);
    c = q;
    rd(`TIOP_OFS_COUNT, c, 32'hFFFF);
    // Running application clock advances the counter again
    @(posedge clk_sys);
    clk_run <= 1'b1;
    repeat (40) @(negedge clk_sys);
    rd(`TIOP_OFS_COUNT, 32'h0, 32'h0);
    check("ext_tick", {31'h0, q[15:0] != c[15:0]}, 32'h1);
    close_out();
  end
endmodule
